// ==== inc/dzsa_pkg.sv ====
// Package for data zone slot addressing: constants, carriers and enums
package dzsa_pkg;

    // Address word fields
    localparam int          SLOT_LSB        = 3;
    localparam int          SLOT_MSB        = 6;
    localparam int          BLK_LSB         = 8;

    // Slot geometry
    localparam logic [3:0]  SMALL_LAST_SLOT = 4'h7;
    localparam logic [3:0]  BIG_SLOT        = 4'h8;
    localparam logic [3:0]  BIG_LAST_BLK    = 4'hc;
    localparam logic [3:0]  SMALL_LAST_BLK  = 4'h1;
    localparam logic [3:0]  MID_LAST_BLK    = 4'h2;
    localparam logic [2:0]  SMALL_TAIL_OFF  = 3'h0;
    localparam logic [2:0]  MID_TAIL_OFF    = 3'h1;
    localparam logic [2:0]  LAST_WORD_OFF   = 3'h7;
    localparam logic [8:0]  BIG_SLOT_BYTES  = 9'h1a0;
    localparam logic [8:0]  SMALL_BYTES     = 9'h024;
    localparam logic [8:0]  MID_BYTES       = 9'h048;

    // Key, signature and digest layout
    localparam logic [7:0]  KEY_LEN         = 8'h48;
    localparam logic [7:0]  PUB_LEN         = 8'h40;
    localparam logic [7:0]  SIG_LEN         = 8'h40;
    localparam logic [7:0]  COORD_LEN       = 8'h20;
    localparam logic [7:0]  KEY_PAD         = 8'h04;
    localparam logic [7:0]  SCRATCH_PAD     = 8'h19;
    localparam logic [8:0]  Y_PAD_OFF       = 9'h024;
    localparam logic [8:0]  X_PAD_OFF       = 9'h000;
    localparam logic [3:0]  NIB_INVALID     = 4'ha;
    localparam logic [3:0]  NIB_VALID       = 4'h5;
    localparam int          HDR_BYTES_DEF   = 4;

    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_KEY_WRITE, OP_VALIDATE, OP_INVALIDATE
    } dzsa_op_t;

    typedef enum logic [1:0] {HK_STORED, HK_DIGEST, HK_PUBOUT, HK_SIG}
        dzsa_hkind_t;

    typedef enum logic [1:0] {HS_ZERO, HS_HDR, HS_MEM} dzsa_hsrc_t;

    typedef struct packed {
        dzsa_op_t    op;
        logic        blk32;
        logic [15:0] addr;
    } dzsa_req_t;

    typedef struct packed {
        logic        we;
        logic        re;
        logic [3:0]  slot;
        logic [8:0]  off;
        logic [31:0] data;
    } dzsa_mem_t;

    typedef struct packed {
        logic       valid;
        dzsa_hsrc_t src;
        logic [6:0] idx;
        logic       last;
    } dzsa_hbyte_t;

endpackage : dzsa_pkg

// ==== src/dzsa_slot_addr.sv ====
// Data zone slot address decode, word sequencing and key byte layout
//
// Behaviour
// - Slots 0-7 hold 36 bytes: block 0 plus word 0 of block 1.
// - Slot 8 holds 416 bytes in blocks 0x0 to 0xC.
// - Slots 9-15 hold 72 bytes: blocks 0, 1 plus two words of block 2.
// - Slot from address bits 6:3, word offset from bits 2:0.
// - Keys travel MSB first, first byte at lowest address, pads zero.
// - Command public key is 64 bytes: X then Y, no padding.
// - Stored public key is 72 bytes: pad4, X32, pad4, Y32.
// - Key write sets top nibble of first byte to 0xA; validate sets 0x5.
// - Key validation hashes exactly the 72 stored bytes in stored layout.
// - Scratch digest: header, 25 zero bytes, then X and Y.
// - Signature is 64 bytes: R then S, each MSB first.
// - Block field: bit 8 for slots 0-7, 11:8 slot 8, 9:8 slots 9-15.
`timescale 1ns/10ps
`default_nettype none

module dzsa_slot_addr
    import dzsa_pkg::*;
#(
    parameter int HDR_BYTES = dzsa_pkg::HDR_BYTES_DEF
) (
    // Clock and reset
    input  wire logic               mclk_i,
    input  wire logic               resetn_i,
    // Word and block requests
    input  wire logic               req_valid_i,
    input  wire dzsa_pkg::dzsa_req_t req_i,
    input  wire logic [31:0]        wdata_i,
    output logic                    req_ready_o,
    output logic                    done_o,
    output logic                    err_o,
    // Memory word port
    output dzsa_pkg::dzsa_mem_t     mem_o,
    // Hash byte sequencer
    input  wire logic               hash_start_i,
    input  wire dzsa_pkg::dzsa_hkind_t hash_kind_i,
    input  wire logic [3:0]         hash_slot_i,
    output dzsa_pkg::dzsa_hbyte_t   hb_o,
    output logic [3:0]              hb_slot_o
);
    import dzsa_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HASH} dzsa_state_t;

    localparam logic [7:0] HDR_LEN = 8'(HDR_BYTES);

    // Block field width follows slot size
    function automatic logic [3:0] blk_field(input logic [3:0]  slot,
                                             input logic [15:0] addr);
        if (slot <= SMALL_LAST_SLOT)
            blk_field = {3'h0, addr[BLK_LSB]};
        else if (slot == BIG_SLOT)
            blk_field = addr[BLK_LSB+3:BLK_LSB];
        else
            blk_field = {2'h0, addr[BLK_LSB+1:BLK_LSB]};
    endfunction : blk_field

    function automatic logic word_ok(input logic [3:0] slot,
                                     input logic [3:0] blk,
                                     input logic [2:0] off);
        if (slot <= SMALL_LAST_SLOT)
            word_ok = (blk < SMALL_LAST_BLK) ||
                      (blk == SMALL_LAST_BLK && off <= SMALL_TAIL_OFF);
        else if (slot == BIG_SLOT)
            word_ok = (blk <= BIG_LAST_BLK);
        else
            word_ok = (blk < MID_LAST_BLK) ||
                      (blk == MID_LAST_BLK && off <= MID_TAIL_OFF);
    endfunction : word_ok

    // Builds one memory word access with key pad and nibble handling
    function automatic dzsa_mem_t mk_word(input dzsa_op_t    op,
                                          input logic [3:0]  slot,
                                          input logic [3:0]  blk,
                                          input logic [2:0]  off,
                                          input logic [31:0] d);
        dzsa_mem_t m;
        m.slot = slot;
        m.off  = {blk, off, 2'b00};
        m.re   = (op == OP_READ);
        m.we   = (op != OP_READ);
        m.data = d;
        if (op == OP_KEY_WRITE && m.off == X_PAD_OFF)
            m.data = {NIB_INVALID, 28'h0};
        else if (op == OP_KEY_WRITE && m.off == Y_PAD_OFF)
            m.data = 32'h0;
        else if (op == OP_VALIDATE)
            m.data = {NIB_VALID, 28'h0};
        else if (op == OP_INVALIDATE)
            m.data = {NIB_INVALID, 28'h0};
        if (op == OP_READ)
            m.data = 32'h0;
        mk_word = m;
    endfunction : mk_word

    // Public key coordinate byte k to its stored offset
    function automatic logic [6:0] key_off(input logic [7:0] k);
        if (k < COORD_LEN)
            key_off = 7'(k + KEY_PAD);
        else
            key_off = 7'(k + KEY_PAD + KEY_PAD);
    endfunction : key_off

    function automatic logic [7:0] hash_len(input dzsa_hkind_t kind);
        case (kind)
            HK_STORED: hash_len = KEY_LEN;
            HK_DIGEST: hash_len = 8'(HDR_LEN + SCRATCH_PAD + PUB_LEN);
            HK_PUBOUT: hash_len = PUB_LEN;
            default:   hash_len = SIG_LEN;
        endcase
    endfunction : hash_len

    dzsa_state_t  state_r, state_nxt;
    dzsa_op_t     op_r, op_nxt;
    dzsa_hkind_t  kind_r, kind_nxt;
    logic [3:0]   slot_r, slot_nxt;
    logic [3:0]   blk_r, blk_nxt;
    logic [2:0]   off_r, off_nxt;
    logic [7:0]   cnt_r, cnt_nxt;
    logic         ready_r, ready_nxt;
    logic         done_r, done_nxt;
    logic         err_r, err_nxt;
    dzsa_mem_t    mem_r, mem_nxt;
    dzsa_hbyte_t  hb_r, hb_nxt;

    // Request decode
    logic [3:0]   d_slot;
    logic [3:0]   d_blk;
    logic [2:0]   d_off;
    logic         d_single;
    logic         d_bad;
    logic         h_bad;
    logic [7:0]   k;

    always_comb begin
        d_slot   = req_i.addr[SLOT_MSB:SLOT_LSB];
        d_single = !req_i.blk32 || req_i.op == OP_VALIDATE ||
                   req_i.op == OP_INVALIDATE;
        d_blk    = blk_field(d_slot, req_i.addr);
        d_off    = d_single ? req_i.addr[2:0] : 3'h0;
        if (req_i.op == OP_VALIDATE || req_i.op == OP_INVALIDATE) begin
            d_blk = 4'h0;
            d_off = 3'h0;
        end
        d_bad = d_single ? !word_ok(d_slot, d_blk, d_off)
                         : !word_ok(d_slot, d_blk, LAST_WORD_OFF);
        if (req_i.op != OP_READ && req_i.op != OP_WRITE &&
            d_slot < BIG_SLOT)
            d_bad = 1'b1;
        h_bad = (hash_kind_i != HK_SIG) && (hash_slot_i < BIG_SLOT);
    end

    always_comb begin
        state_nxt = state_r;
        op_nxt    = op_r;
        kind_nxt  = kind_r;
        slot_nxt  = slot_r;
        blk_nxt   = blk_r;
        off_nxt   = off_r;
        cnt_nxt   = cnt_r;
        done_nxt  = 1'b0;
        err_nxt   = 1'b0;
        mem_nxt   = '0;
        hb_nxt    = '0;
        k         = 8'h0;
        case (state_r)
            ST_IDLE: begin
                if (req_valid_i) begin
                    if (d_bad) begin
                        err_nxt  = 1'b1;
                        done_nxt = 1'b1;
                    end else begin
                        mem_nxt = mk_word(req_i.op, d_slot, d_blk, d_off,
                                          wdata_i);
                        op_nxt   = req_i.op;
                        slot_nxt = d_slot;
                        blk_nxt  = d_blk;
                        off_nxt  = 3'h1;
                        if (d_single)
                            done_nxt = 1'b1;
                        else
                            state_nxt = ST_RUN;
                    end
                end else if (hash_start_i) begin
                    if (h_bad) begin
                        err_nxt  = 1'b1;
                        done_nxt = 1'b1;
                    end else begin
                        kind_nxt  = hash_kind_i;
                        slot_nxt  = hash_slot_i;
                        cnt_nxt   = 8'h0;
                        state_nxt = ST_HASH;
                    end
                end
            end
            ST_RUN: begin
                mem_nxt = mk_word(op_r, slot_r, blk_r, off_r, wdata_i);
                off_nxt = 3'(off_r + 3'h1);
                if (off_r == LAST_WORD_OFF) begin
                    done_nxt  = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_HASH: begin
                hb_nxt.valid = 1'b1;
                hb_nxt.src   = HS_MEM;
                hb_nxt.idx   = cnt_r[6:0];
                if (kind_r == HK_PUBOUT)
                    hb_nxt.idx = key_off(cnt_r);
                else if (kind_r == HK_DIGEST) begin
                    if (cnt_r < HDR_LEN)
                        hb_nxt.src = HS_HDR;
                    else if (cnt_r < 8'(HDR_LEN + SCRATCH_PAD)) begin
                        hb_nxt.src = HS_ZERO;
                        hb_nxt.idx = 7'h0;
                    end else begin
                        k          = 8'(cnt_r - HDR_LEN - SCRATCH_PAD);
                        hb_nxt.idx = key_off(k);
                    end
                end
                cnt_nxt = 8'(cnt_r + 8'h1);
                if (cnt_r == 8'(hash_len(kind_r) - 8'h1)) begin
                    hb_nxt.last = 1'b1;
                    done_nxt    = 1'b1;
                    state_nxt   = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        ready_nxt = (state_nxt == ST_IDLE);
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ST_IDLE;
            op_r    <= OP_READ;
            kind_r  <= HK_STORED;
            slot_r  <= 4'h0;
            blk_r   <= 4'h0;
            off_r   <= 3'h0;
            cnt_r   <= 8'h0;
            ready_r <= 1'b1;
            done_r  <= 1'b0;
            err_r   <= 1'b0;
            mem_r   <= '0;
            hb_r    <= '0;
        end else begin
            state_r <= state_nxt;
            op_r    <= op_nxt;
            kind_r  <= kind_nxt;
            slot_r  <= slot_nxt;
            blk_r   <= blk_nxt;
            off_r   <= off_nxt;
            cnt_r   <= cnt_nxt;
            ready_r <= ready_nxt;
            done_r  <= done_nxt;
            err_r   <= err_nxt;
            mem_r   <= mem_nxt;
            hb_r    <= hb_nxt;
        end
    end

    assign req_ready_o = ready_r;
    assign done_o      = done_r;
    assign err_o       = err_r;
    assign mem_o       = mem_r;
    assign hb_o        = hb_r;
    assign hb_slot_o   = slot_r;

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    logic req_take;
    logic hash_take;
    assign req_take  = ready_r && req_valid_i;
    assign hash_take = ready_r && !req_valid_i && hash_start_i;

    property p_bad_word;
        req_take && d_bad |=> err_o && !mem_o.we && !mem_o.re;
    endproperty
    a_bad_word: assert property (p_bad_word)
        else $error("invalid word not rejected");

    property p_blk_small;
        req_take && req_i.op == OP_READ && req_i.blk32 &&
        req_i.addr[6:3] <= 4'h7 && req_i.addr[8] |=> err_o;
    endproperty
    a_blk_small: assert property (p_blk_small)
        else $error("partial block accepted as block transfer");

    property p_burst;
        req_take && !d_bad && !d_single && req_i.op == OP_READ
            |=> mem_o.re [*8] ##1 (!mem_o.re || $past(req_take));
    endproperty
    a_burst: assert property (p_burst)
        else $error("block read not eight words");

    property p_big_range;
        (mem_o.we || mem_o.re) && mem_o.slot == 4'h8
            |-> mem_o.off < BIG_SLOT_BYTES;
    endproperty
    a_big_range: assert property (p_big_range)
        else $error("slot 8 access beyond 416 bytes");

    property p_small_range;
        (mem_o.we || mem_o.re) && mem_o.slot <= 4'h7
            |-> mem_o.off < SMALL_BYTES;
    endproperty
    a_small_range: assert property (p_small_range)
        else $error("small slot access beyond 36 bytes");

    property p_mid_range;
        (mem_o.we || mem_o.re) && mem_o.slot > 4'h8
            |-> mem_o.off < MID_BYTES;
    endproperty
    a_mid_range: assert property (p_mid_range)
        else $error("mid slot access beyond 72 bytes");

    property p_slot_decode;
        req_take && !d_bad && req_i.op == OP_READ
            |=> mem_o.slot == $past(req_i.addr[6:3]) &&
                mem_o.off[4:2] == ($past(req_i.blk32) ? 3'h0
                                   : $past(req_i.addr[2:0]));
    endproperty
    a_slot_decode: assert property (p_slot_decode)
        else $error("slot or offset decoded wrongly");

    property p_key_nibble;
        mem_o.we && op_r == OP_KEY_WRITE && mem_o.off == 9'h0
            |-> mem_o.data == {4'ha, 28'h0};
    endproperty
    a_key_nibble: assert property (p_key_nibble)
        else $error("key write first word not marked invalid");

    property p_validate;
        req_take && !d_bad && req_i.op == OP_VALIDATE
            |=> mem_o.we && mem_o.off == 9'h0 &&
                mem_o.data[31:28] == 4'h5 && done_o;
    endproperty
    a_validate: assert property (p_validate)
        else $error("validate did not write valid nibble");

    property p_ypad;
        mem_o.we && op_r == OP_KEY_WRITE && mem_o.off == 9'h24
            |-> mem_o.data == 32'h0;
    endproperty
    a_ypad: assert property (p_ypad)
        else $error("Y pad word not zero");

    property p_stored_len;
        hash_take && !h_bad && hash_kind_i == HK_STORED
            |=> !hb_o.valid ##72 hb_o.valid && hb_o.last && hb_o.idx == 7'h47;
    endproperty
    a_stored_len: assert property (p_stored_len)
        else $error("stored key hash not 72 bytes");

    property p_digest_pad;
        hb_o.valid && kind_r == HK_DIGEST && hb_o.src == HS_MEM
            |-> $past(hb_o.src) == HS_MEM || $past(hb_o.src, 1) == HS_ZERO;
    endproperty
    a_digest_pad: assert property (p_digest_pad)
        else $error("digest key bytes not after pad");

    c_block_write: cover property (req_take && !d_bad && !d_single &&
                                   req_i.op == OP_KEY_WRITE);
    c_big_last: cover property (mem_o.re && mem_o.slot == 4'h8 &&
                                mem_o.off == 9'h19c);
    c_digest_end: cover property (hb_o.last && kind_r == HK_DIGEST);
    c_reject: cover property (err_o);

endmodule : dzsa_slot_addr

`default_nettype wire

// ==== tb/dzsa_host.sv ====
// Host model issuing word, block and hash requests
`timescale 1ns/10ps
`default_nettype none

module dzsa_host
    import dzsa_pkg::*;
(
    // Clock
    input  wire logic                  mclk_i,
    // Answers from the block
    input  wire logic                  ready_i,
    input  wire logic                  done_i,
    input  wire logic                  err_i,
    input  wire dzsa_pkg::dzsa_mem_t   mem_i,
    input  wire dzsa_pkg::dzsa_hbyte_t hb_i,
    // Requests to the block
    output logic                       valid_o,
    output dzsa_pkg::dzsa_req_t        req_o,
    output logic [31:0]                wdata_o,
    output logic                       hstart_o,
    output dzsa_pkg::dzsa_hkind_t      hkind_o,
    output logic [3:0]                 hslot_o
);
    import dzsa_pkg::*;

    logic [31:0] words [8];
    dzsa_mem_t   acc_q [$];
    dzsa_hbyte_t hb_q [$];
    logic        got_err;
    logic        got_done;

    initial begin
        valid_o = 1'b0;
        req_o = '0;
        wdata_o = '0;
        hstart_o = 1'b0;
        hkind_o = HK_STORED;
        hslot_o = 4'h0;
    end

    // Word or block, in any mix the caller picks
    // Key ops go to slots 8-15 unless a refusal is wanted
    task automatic run_req(input dzsa_op_t op, input logic blk,
                           input logic [15:0] a);
        int n;
        acc_q.delete();
        got_err = 1'b0;
        got_done = 1'b0;
        @(negedge mclk_i);
        valid_o = 1'b1;
        req_o = '{op, blk, a};
        wdata_o = words[0];
        while (ready_i !== 1'b1) @(negedge mclk_i);
        for (n = 1; n < 40; n++) begin
            @(negedge mclk_i);
            if (n == 1) begin
                valid_o = 1'b0;
                req_o = ~req_o;
            end
            wdata_o = (n < 8) ? words[n] : ~wdata_o;
            if (mem_i.we || mem_i.re) acc_q.push_back(mem_i);
            if (done_i === 1'b1) begin
                got_err = err_i;
                got_done = 1'b1;
                break;
            end
        end
    endtask : run_req

    task automatic run_hash(input dzsa_hkind_t k, input logic [3:0] s);
        int n;
        hb_q.delete();
        got_err = 1'b0;
        got_done = 1'b0;
        @(negedge mclk_i);
        hstart_o = 1'b1;
        hkind_o = k;
        hslot_o = s;
        while (ready_i !== 1'b1) @(negedge mclk_i);
        for (n = 1; n < 200; n++) begin
            @(negedge mclk_i);
            hstart_o = 1'b0;
            if (hb_i.valid) hb_q.push_back(hb_i);
            if (done_i === 1'b1) begin
                got_err = err_i;
                got_done = 1'b1;
                break;
            end
        end
    endtask : run_hash
endmodule : dzsa_host

`default_nettype wire

// ==== tb/test_data_zone_slot_addressing.sv ====
// Self-checking bench for the slot address decoder
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin \
    err_total++; $display("wrong value at %0t: %s", $time, m); end end

module test_data_zone_slot_addressing;
    import dzsa_pkg::*;
    localparam int HDR = 5;
    logic        mclk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        req_valid, hstart, ready, done, err;
    dzsa_req_t   req;
    logic [31:0] wdata;
    dzsa_mem_t   mem;
    dzsa_hkind_t hkind;
    logic [3:0]  hslot, hb_slot;
    dzsa_hbyte_t hb;
    int          err_total = 0;
    int          checks_done = 0;
    int          cyc = 0;
    logic [15:0] lfsr = 16'h002b;
    logic [19:0] cases [16] = '{20'h00100, 20'h00101, 20'h10000,
        20'h10100, 20'h30c40, 20'h20d40, 20'h10148, 20'h00249, 20'h0024a,
        20'h10248, 20'h50050, 20'h50150, 20'h40018, 20'h60050, 20'h80050,
        20'h60010};

    dzsa_slot_addr #(.HDR_BYTES(HDR)) u_dut (.mclk_i(mclk_i),
        .resetn_i(resetn_i), .req_valid_i(req_valid), .req_i(req),
        .wdata_i(wdata), .req_ready_o(ready), .done_o(done), .err_o(err),
        .mem_o(mem), .hash_start_i(hstart), .hash_kind_i(hkind),
        .hash_slot_i(hslot), .hb_o(hb), .hb_slot_o(hb_slot));

    dzsa_host u_host (.mclk_i(mclk_i), .ready_i(ready), .done_i(done),
        .err_i(err), .mem_i(mem), .hb_i(hb), .valid_o(req_valid),
        .req_o(req), .wdata_o(wdata), .hstart_o(hstart), .hkind_o(hkind),
        .hslot_o(hslot));

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd

    function automatic logic [3:0] blk_of(logic [15:0] a);
        if (a[6:3] < 4'h8) return {3'h0, a[8]};
        if (a[6:3] == 4'h8) return a[11:8];
        return {2'h0, a[9:8]};
    endfunction : blk_of

    function automatic logic ok_word(logic [3:0] s, b, logic [2:0] o);
        if (s < 4'h8) return b == 0 || (b == 1 && o == 0);
        if (s == 4'h8) return b <= 4'hc;
        return b <= 1 || (b == 2 && o <= 1);
    endfunction : ok_word

    task automatic xfer(dzsa_op_t op, logic blk, logic [15:0] a);
        logic [3:0]  s, b;
        logic        ok, kop;
        logic [8:0]  o;
        logic [31:0] d;
        int          n;
        s = a[6:3];
        b = blk_of(a);
        kop = op inside {OP_VALIDATE, OP_INVALIDATE};
        ok = kop || ok_word(s, b, blk ? 3'h7 : a[2:0]);
        if (op != OP_READ && op != OP_WRITE && s < 4'h8) ok = 1'b0;
        for (n = 0; n < 8; n++) u_host.words[n] = {rnd(), rnd()};
        if (op == OP_WRITE && blk && s < 4'h8)
            u_host.words[0] = 32'h0;
        u_host.run_req(op, blk, a);
        n = !ok ? 0 : (blk && !kop) ? 8 : 1;
        `CHK(u_host.got_err, !ok, "error flag")
        `CHK(u_host.acc_q.size(), n, "access count")
        `CHK(u_host.got_done, 1'b1, "done pulse")
        for (int k = 0; k < u_host.acc_q.size(); k++) begin
            o = kop ? 9'h0 : {b, 5'h0} + {(blk ? 3'(k) : a[2:0]), 2'h0};
            d = (op == OP_READ) ? 32'h0 : u_host.words[k];
            if (op == OP_KEY_WRITE && o == 9'h024) d = 32'h0;
            if (op != OP_WRITE && op != OP_READ && o == 9'h0)
                d = {op == OP_VALIDATE ? 4'h5 : 4'ha, 28'h0};
            `CHK(u_host.acc_q[k].off, o, "offset")
            `CHK(u_host.acc_q[k].slot, s, "slot")
            `CHK(u_host.acc_q[k].data, d, "data word")
            `CHK(u_host.acc_q[k].re, op == OP_READ, "read strobe")
            `CHK(u_host.acc_q[k].we, op != OP_READ, "write strobe")
        end
    endtask : xfer

    task automatic hchk(dzsa_hkind_t k, logic [3:0] s);
        logic [8:0] ex [$];
        logic       ok;
        int         j;
        ok = (k == HK_SIG) || s >= 4'h8;
        if (k == HK_DIGEST) begin
            for (j = 0; j < HDR; j++) ex.push_back({HS_HDR, 7'(j)});
            for (j = 0; j < 25; j++) ex.push_back({HS_ZERO, 7'h0});
        end
        for (j = 0; j < 72; j++) begin
            if (k == HK_STORED || (k == HK_SIG && j < 64) ||
                (k inside {HK_DIGEST, HK_PUBOUT} && j % 36 >= 4))
                ex.push_back({HS_MEM, 7'(j)});
        end
        u_host.run_hash(k, s);
        `CHK(u_host.got_err, !ok, "hash error flag")
        `CHK(u_host.got_done, 1'b1, "hash done pulse")
        if (ok) `CHK(hb_slot, s, "hash slot")
        j = ok ? ex.size() : 0;
        `CHK(u_host.hb_q.size(), j, "hash length")
        for (int i = 0; i < u_host.hb_q.size(); i++) begin
            `CHK(u_host.hb_q[i].src, ex[i][8:7], "byte source")
            if (ex[i][8:7] != HS_ZERO)
                `CHK(u_host.hb_q[i].idx, ex[i][6:0], "byte index")
            `CHK(u_host.hb_q[i].last, i == j - 1, "last flag")
        end
    endtask : hchk

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    initial begin
        forever #10 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 10000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        logic [15:0] a;
        logic        blk;
        repeat (10) @(negedge mclk_i);
        `CHK(ready, 1'b1, "ready in reset")
        `CHK({done, err, mem, hb, hb_slot}, '0, "outputs in reset")
        resetn_i = 1'b1;
        foreach (cases[i])
            xfer(dzsa_op_t'(cases[i][19:17]), cases[i][16], cases[i][15:0]);
        // Private key parameter, then encoded certificate in a mid slot
        xfer(OP_WRITE, 1'b1, 16'h0008);
        xfer(OP_WRITE, 1'b0, 16'h0108);
        xfer(OP_WRITE, 1'b1, 16'h0050);
        xfer(OP_WRITE, 1'b1, 16'h0150);
        xfer(OP_WRITE, 1'b0, 16'h0250);
        xfer(OP_WRITE, 1'b0, 16'h0251);
        $display("corner transfers done");
        for (int i = 0; i < 150; i++) begin
            a = rnd();
            blk = a[7];
            if (blk) a[2:0] = 3'h0;
            xfer(dzsa_op_t'(3'(rnd() % 5)), blk, a);
        end
        $display("random transfers done");
        hchk(HK_STORED, 4'h9);
        hchk(HK_DIGEST, 4'hc);
        hchk(HK_PUBOUT, 4'h8);
        hchk(HK_SIG, 4'h3);
        hchk(HK_STORED, 4'h5);
        hchk(HK_PUBOUT, 4'h0);
        $display("hash sequences done");
        stop_test();
    end
endmodule : test_data_zone_slot_addressing

`default_nettype wire
